// File: dio_pkg.sv
// Purpose: shared constants and carriers for the digital channel engine
// Assumes: 10 MHz system clock
// Notes:   all timing counts derive from the clock rate here
package dio_pkg;
  localparam int CLK_HZ        = 10000000;
  localparam int TICK_US       = 100;     // filter/pulse unit, 0.1 ms
  localparam int TICK_CYCLES   = (CLK_HZ / 1000000) * TICK_US;
  localparam int GATE_MS       = 1000;    // frequency gate interval
  localparam int GATE_TICKS    = GATE_MS * 1000 / TICK_US;
  localparam int CNT_W         = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [15:0]      W16_ZERO = 16'h0000;
  localparam logic [15:0]      W16_ONE  = 16'h0001;

  typedef enum logic [2:0] {
    IN_LEVEL, IN_COUNT, IN_LATCH_RISE, IN_LATCH_FALL, IN_FREQ
  } in_mode_t;

  typedef enum logic [1:0] {
    OUT_DIRECT, OUT_PULSE, OUT_DELAY_RISE, OUT_DELAY_FALL
  } out_mode_t;

  typedef struct packed {
    in_mode_t    mode;
    logic        invert;
    logic        retain;
    logic [15:0] min_high;
    logic [15:0] min_low;
  } in_cfg_t;

  typedef struct packed {
    out_mode_t   mode;
    logic        continuous;
    logic [15:0] high_width;
    logic [15:0] low_width;
    logic [31:0] total;
    logic [15:0] delay;
    logic        fail_safe;
  } out_cfg_t;
endpackage : dio_pkg

// File: dio_channel.sv
// Purpose: one digital input and one digital output channel with watchdogs
// Assumes: inputs synchronous to CLK; host commands are one-cycle pulses
// Notes:   retention is modelled by a restore value loaded on command
`timescale 1ns/1ps
module dio_channel #(
  // gate length in ticks; the default makes the frequency read in Hz
  parameter int GATE_TICKS = dio_pkg::GATE_TICKS
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RESETN,
  // field side
  input  wire logic               SENSED_INPUT,
  output logic                    FIELD_OUT,
  // input configuration and commands
  input  wire dio_pkg::in_cfg_t   IN_CFG,
  input  wire logic               COUNT_START,
  input  wire logic               COUNT_STOP,
  input  wire logic               COUNT_CLEAR,
  input  wire logic               LATCH_CLEAR,
  input  wire logic               POWER_RESTORE,
  input  wire logic [31:0]        RETAINED_COUNT,
  // input status
  output logic                    INPUT_STATUS,
  output logic                    LATCH_STATUS,
  output logic [31:0]             COUNT_VALUE,
  output logic                    COUNT_RUNNING,
  output logic [31:0]             FREQ_VALUE,
  // output configuration, commands and status
  input  wire dio_pkg::out_cfg_t  OUT_CFG,
  input  wire logic               OUT_LEVEL,
  input  wire logic               PULSE_START,
  output logic                    OUTPUT_STATUS,
  // watchdogs
  input  wire logic               HOST_PACKET,
  input  wire logic [15:0]        HOST_IDLE,
  input  wire logic               PEER_PACKET,
  input  wire logic [15:0]        PEER_IDLE,
  input  wire logic               PEER_REPORT_EN,
  output logic                    HOST_TIMEOUT,
  output logic                    PEER_TIMEOUT,
  output logic                    FALLBACK_OUTPUT_VALUE
);
  logic rst_meta, rst_n;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  localparam logic [15:0] W16 = dio_pkg::W16_ZERO;

  // 0.1 ms tick shared by filter, pulse, delay and watchdog timing
  logic [15:0] tick_div;
  logic        tick;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_div <= W16;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_div == 16'(dio_pkg::TICK_CYCLES - 1));
      if (tick_div == 16'(dio_pkg::TICK_CYCLES - 1)) tick_div <= W16;
      else tick_div <= tick_div + dio_pkg::W16_ONE;
    end
  end

  // width never counts as zero, so a setting of 0 behaves as 1
  function automatic logic [15:0] min1(input logic [15:0] w);
    min1 = (w == W16) ? dio_pkg::W16_ONE : w;
  endfunction : min1

  // input conditioning
  logic raw, filt, filt_d;
  logic [15:0] stable;
  assign raw = SENSED_INPUT ^ IN_CFG.invert;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      filt   <= 1'b0;
      stable <= W16;
    end else if (raw == filt) begin
      stable <= W16;
    end else if (tick) begin
      if (stable + dio_pkg::W16_ONE >=
          min1(raw ? IN_CFG.min_high : IN_CFG.min_low)) begin
        filt   <= raw;
        stable <= W16;
      end else stable <= stable + dio_pkg::W16_ONE;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) filt_d <= 1'b0;
    else filt_d <= filt;
  end
  logic rise, fall;
  assign rise = filt & ~filt_d;
  assign fall = ~filt & filt_d;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) INPUT_STATUS <= 1'b0;
    else INPUT_STATUS <= filt;
  end

  // counter
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) COUNT_RUNNING <= 1'b0;
    else if (COUNT_STOP) COUNT_RUNNING <= 1'b0;
    else if (COUNT_START) COUNT_RUNNING <= 1'b1;
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) COUNT_VALUE <= dio_pkg::CNT_ZERO;
    else if (COUNT_CLEAR) COUNT_VALUE <= dio_pkg::CNT_ZERO;
    else if (POWER_RESTORE)
      COUNT_VALUE <= IN_CFG.retain ? RETAINED_COUNT
                                   : dio_pkg::CNT_ZERO;
    else if (IN_CFG.mode == dio_pkg::IN_COUNT && COUNT_RUNNING && rise)
      COUNT_VALUE <= COUNT_VALUE + 32'h0000_0001;
  end

  // latch: set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) LATCH_STATUS <= 1'b0;
    else if ((IN_CFG.mode == dio_pkg::IN_LATCH_RISE && rise) ||
             (IN_CFG.mode == dio_pkg::IN_LATCH_FALL && fall))
      LATCH_STATUS <= 1'b1;
    else if (LATCH_CLEAR) LATCH_STATUS <= 1'b0;
  end

  // frequency: rising edges per gate, in Hz with the one-second default
  logic [31:0] gate, edges;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gate       <= dio_pkg::CNT_ZERO;
      edges      <= dio_pkg::CNT_ZERO;
      FREQ_VALUE <= dio_pkg::CNT_ZERO;
    end else if (IN_CFG.mode != dio_pkg::IN_FREQ) begin
      gate  <= dio_pkg::CNT_ZERO;
      edges <= dio_pkg::CNT_ZERO;
    end else if (tick && gate == 32'(GATE_TICKS - 1)) begin
      FREQ_VALUE <= edges + {31'h0, rise};
      edges      <= dio_pkg::CNT_ZERO;
      gate       <= dio_pkg::CNT_ZERO;
    end else begin
      if (tick) gate <= gate + 32'h0000_0001;
      if (rise) edges <= edges + 32'h0000_0001;
    end
  end

  // pulse generator
  logic        pulse_on, pulse_lvl;
  logic [15:0] ptime;
  logic [31:0] sent;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pulse_on  <= 1'b0;
      pulse_lvl <= 1'b0;
      ptime     <= W16;
      sent      <= dio_pkg::CNT_ZERO;
    end else if (OUT_CFG.mode != dio_pkg::OUT_PULSE) begin
      pulse_on  <= 1'b0;
      pulse_lvl <= 1'b0;
    end else if (PULSE_START && !pulse_on) begin
      pulse_on  <= 1'b1;
      pulse_lvl <= 1'b1;
      ptime     <= W16;
      sent      <= dio_pkg::CNT_ZERO;
    end else if (pulse_on && tick) begin
      if (ptime + dio_pkg::W16_ONE >=
          min1(pulse_lvl ? OUT_CFG.high_width
                         : OUT_CFG.low_width)) begin
        ptime <= W16;
        if (pulse_lvl) begin
          pulse_lvl <= 1'b0;
          sent      <= sent + 32'h0000_0001;
          if (!OUT_CFG.continuous && sent + 32'h0000_0001 >= OUT_CFG.total)
            pulse_on <= 1'b0;
        end else pulse_lvl <= 1'b1;
      end else ptime <= ptime + dio_pkg::W16_ONE;
    end
  end

  // delayed level
  logic        dly_lvl;
  logic [15:0] dtime;
  logic        slow_edge;
  assign slow_edge =
    (OUT_CFG.mode == dio_pkg::OUT_DELAY_RISE && OUT_LEVEL && !dly_lvl) ||
    (OUT_CFG.mode == dio_pkg::OUT_DELAY_FALL && !OUT_LEVEL && dly_lvl);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dly_lvl <= 1'b0;
      dtime   <= W16;
    end else if (OUT_LEVEL == dly_lvl || !slow_edge) begin
      dly_lvl <= OUT_LEVEL;
      dtime   <= W16;
    end else if (tick) begin
      if (dtime + dio_pkg::W16_ONE >= min1(OUT_CFG.delay)) begin
        dly_lvl <= OUT_LEVEL;
        dtime   <= W16;
      end else dtime <= dtime + dio_pkg::W16_ONE;
    end
  end

  // watchdogs counted in ticks; idle of zero disables
  logic [15:0] host_idle_t, peer_idle_t;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      host_idle_t  <= W16;
      HOST_TIMEOUT <= 1'b0;
    end else if (HOST_PACKET) begin
      host_idle_t  <= W16;
      HOST_TIMEOUT <= 1'b0;
    end else if (tick && HOST_IDLE != W16 && !HOST_TIMEOUT) begin
      host_idle_t <= host_idle_t + dio_pkg::W16_ONE;
      if (host_idle_t >= HOST_IDLE) // tick idle+1; no wrap at 65535
        HOST_TIMEOUT <= 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      peer_idle_t  <= W16;
      PEER_TIMEOUT <= 1'b0;
    end else if (PEER_PACKET) begin
      peer_idle_t  <= W16;
      PEER_TIMEOUT <= 1'b0;
    end else if (tick && PEER_IDLE != W16 && !PEER_TIMEOUT) begin
      peer_idle_t <= peer_idle_t + dio_pkg::W16_ONE;
      if (peer_idle_t >= PEER_IDLE)
        PEER_TIMEOUT <= 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) FALLBACK_OUTPUT_VALUE <= 1'b0;
    else FALLBACK_OUTPUT_VALUE <= PEER_TIMEOUT && PEER_REPORT_EN;
  end

  // output select
  logic next_out;
  always_comb begin
    case (OUT_CFG.mode)
      dio_pkg::OUT_DIRECT:     next_out = OUT_LEVEL;
      dio_pkg::OUT_PULSE:      next_out = pulse_lvl;
      dio_pkg::OUT_DELAY_RISE: next_out = dly_lvl;
      dio_pkg::OUT_DELAY_FALL: next_out = dly_lvl;
      default:                 next_out = 1'b0;
    endcase
    if (OUT_CFG.fail_safe && HOST_TIMEOUT) next_out = 1'b1;
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      FIELD_OUT     <= 1'b0;
      OUTPUT_STATUS <= 1'b0;
    end else begin
      FIELD_OUT     <= next_out;
      OUTPUT_STATUS <= next_out;
    end
  end

  a_latch_sticky: assert property (
    @(posedge CLK) disable iff (!rst_n)
    LATCH_STATUS && !LATCH_CLEAR |=> LATCH_STATUS)
    else $error("latch dropped without clear");
  a_count_hold: assert property (
    @(posedge CLK) disable iff (!rst_n)
    !COUNT_RUNNING && !COUNT_CLEAR && !POWER_RESTORE |=>
    $stable(COUNT_VALUE))
    else $error("count moved while stopped");
  a_count_clear: assert property (
    @(posedge CLK) disable iff (!rst_n)
    COUNT_CLEAR |=> COUNT_VALUE == 32'h0)
    else $error("count not cleared");
  a_fail_safe: assert property (
    @(posedge CLK) disable iff (!rst_n)
    OUT_CFG.fail_safe && HOST_TIMEOUT |=> FIELD_OUT)
    else $error("fail-safe output not high");
  a_direct_follow: assert property (
    @(posedge CLK) disable iff (!rst_n)
    OUT_CFG.mode == dio_pkg::OUT_DIRECT && !HOST_TIMEOUT |=>
    FIELD_OUT == $past(OUT_LEVEL))
    else $error("direct output wrong");
  a_rise_latch: assert property (
    @(posedge CLK) disable iff (!rst_n)
    IN_CFG.mode == dio_pkg::IN_LATCH_RISE && rise |=> LATCH_STATUS)
    else $error("rise not latched");
  a_fall_latch: assert property (
    @(posedge CLK) disable iff (!rst_n)
    IN_CFG.mode == dio_pkg::IN_LATCH_FALL && fall |=> LATCH_STATUS)
    else $error("fall not latched");
  a_host_wdog: assert property (
    @(posedge CLK) disable iff (!rst_n)
    HOST_PACKET |=> !HOST_TIMEOUT)
    else $error("timeout despite packet");
  c_count: cover property (@(posedge CLK) rise && COUNT_RUNNING);
  c_burst_end: cover property (@(posedge CLK) $fell(pulse_on));
  c_timeout: cover property (@(posedge CLK) $rose(HOST_TIMEOUT));
endmodule : dio_channel

// File: dio_field.sv
// Purpose: field side of one channel, a contact source and an actuator load
// Assumes: one clock; the bench steers the contact level through hold
// Notes:   pulse counts only grow, so the bench compares deltas
`timescale 1ns/1ps
module dio_field (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // channel pins
  input  wire logic FIELD_OUT,
  output logic      SENSED_INPUT
);
  int   edges;
  int   high_len;
  int   run_len;
  logic last_out;

  initial SENSED_INPUT = 1'b0;

  // level changes land on a clock edge, never between edges
  task automatic hold(input logic v, input int cycles);
    @(posedge CLK);
    SENSED_INPUT <= v;
    repeat (cycles) @(posedge CLK);
  endtask : hold

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      edges    <= 0;
      high_len <= 0;
      run_len  <= 0;
      last_out <= 1'b0;
    end else begin
      last_out <= FIELD_OUT;
      run_len  <= FIELD_OUT ? run_len + 1 : 0;
      if (FIELD_OUT && !last_out) edges <= edges + 1;
      if (!FIELD_OUT && last_out) high_len <= run_len;
    end
  end
endmodule : dio_field

// File: digital_io_channel_engine_bench.sv
// Purpose: self-checking bench for one digital channel
// Assumes: tick of 1000 cycles; a four-tick frequency gate keeps runs short
// Notes:   random levels come from an xorshift seeded at 5
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end \
end
`define PULSE(s) s <= 1'b1; @(posedge clk); s <= 1'b0; repeat (2) @(posedge clk);
module digital_io_channel_engine_bench;
  localparam int TK = dio_pkg::TICK_CYCLES;
  localparam int GATE = 4;
  logic              clk;
  logic              resetn = 1'b0;
  logic              sensed;
  logic              field_out;
  dio_pkg::in_cfg_t  icfg = '0;
  dio_pkg::out_cfg_t ocfg = '0;
  logic              count_start = 1'b0, count_stop = 1'b0;
  logic              count_clear = 1'b0, latch_clear = 1'b0;
  logic              power_restore = 1'b0, out_level = 1'b0;
  logic              pulse_start = 1'b0, host_packet = 1'b0;
  logic              peer_packet = 1'b0, peer_report_en = 1'b0;
  logic [31:0]       retained = 32'h0;
  logic [15:0]       host_idle = 16'h0, peer_idle = 16'h0;
  logic              input_status, latch_status, count_running;
  logic              output_status, host_timeout, peer_timeout, fallback;
  logic [31:0]       count_value, freq_value, seed = 32'h5, r;
  logic              lvl, saw_in = 1'b0;
  int                mismatches = 0, cmp_count = 0, e0;

  dio_field field (.CLK(clk), .RESETN(resetn), .FIELD_OUT(field_out),
                   .SENSED_INPUT(sensed));

  dio_channel #(.GATE_TICKS(GATE)) uut (.CLK(clk), .RESETN(resetn),
    .SENSED_INPUT(sensed),
    .FIELD_OUT(field_out), .IN_CFG(icfg), .COUNT_START(count_start),
    .COUNT_STOP(count_stop), .COUNT_CLEAR(count_clear),
    .LATCH_CLEAR(latch_clear), .POWER_RESTORE(power_restore),
    .RETAINED_COUNT(retained), .INPUT_STATUS(input_status),
    .LATCH_STATUS(latch_status), .COUNT_VALUE(count_value),
    .COUNT_RUNNING(count_running), .FREQ_VALUE(freq_value),
    .OUT_CFG(ocfg), .OUT_LEVEL(out_level), .PULSE_START(pulse_start),
    .OUTPUT_STATUS(output_status), .HOST_PACKET(host_packet),
    .HOST_IDLE(host_idle), .PEER_PACKET(peer_packet),
    .PEER_IDLE(peer_idle), .PEER_REPORT_EN(peer_report_en),
    .HOST_TIMEOUT(host_timeout), .PEER_TIMEOUT(peer_timeout),
    .FALLBACK_OUTPUT_VALUE(fallback));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic cond(input logic v, input logic inv);
    return v ^ inv;
  endfunction : cond

  // rising edges per gate for a square wave of the given period in ticks
  function automatic int freq_exp(input int gate, input int period);
    return gate / period;
  endfunction : freq_exp

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask : ticks

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // catches a glitch on the filtered level between sample points
  always @(posedge clk) if (input_status === 1'b1) saw_in <= 1'b1;

  // run is about 88 k cycles, so this only fires on a hang
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("reset field", 1'b0, field_out)
    icfg.invert <= 1'b1;
    ticks(3);
    `CHK("inverted idle", cond(1'b0, 1'b1), input_status)
    icfg.invert <= 1'b0;
    icfg.min_high <= 16'h0002;
    icfg.min_low <= 16'h0002;
    field.hold(1'b0, 4 * TK);
    saw_in <= 1'b0;
    field.hold(1'b1, 500);
    field.hold(1'b0, 4 * TK);
    `CHK("glitch", 1'b0, saw_in)
    field.hold(1'b1, 5 * TK);
    `CHK("wide pulse", cond(1'b1, 1'b0), input_status)
    icfg.mode <= dio_pkg::IN_COUNT;
    icfg.min_high <= 16'h0001;
    icfg.min_low <= 16'h0001;
    field.hold(1'b0, 3 * TK);
    `PULSE(count_start)
    `CHK("running", 1'b1, count_running)
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        `CHK("count two", 32'h2, count_value)
        `PULSE(count_stop)
        `CHK("stopped", 1'b0, count_running)
      end
      field.hold(1'b1, 2 * TK);
      field.hold(1'b0, 2 * TK);
    end
    `CHK("count held", 32'h2, count_value)
    `PULSE(count_clear)
    `CHK("cleared", 32'h0, count_value)
    retained <= rnd();
    icfg.retain <= 1'b1;
    `PULSE(power_restore)
    `CHK("restored", retained, count_value)
    icfg.retain <= 1'b0;
    `PULSE(power_restore)
    `CHK("not retained", 32'h0, count_value)
    // corner: one rise from the top of the range must wrap
    retained <= 32'hffff_ffff;
    icfg.retain <= 1'b1;
    `PULSE(power_restore)
    `PULSE(count_start)
    field.hold(1'b1, 2 * TK);
    field.hold(1'b0, 2 * TK);
    `CHK("count wrap", 32'h0, count_value)
    for (int i = 0; i < 2; i++) begin
      icfg.mode <= i ? dio_pkg::IN_LATCH_FALL : dio_pkg::IN_LATCH_RISE;
      `PULSE(latch_clear)
      field.hold(1'b1, 2 * TK);
      `CHK("latch on rise", ~i[0], latch_status)
      field.hold(1'b0, 2 * TK);
      `CHK("latch kept", 1'b1, latch_status)
      `PULSE(latch_clear)
      `CHK("latch cleared", 1'b0, latch_status)
    end
    // one-tick levels: every level meets exactly one filter tick
    icfg.mode <= dio_pkg::IN_FREQ;
    repeat (7) begin
      field.hold(1'b1, TK - 1);
      field.hold(1'b0, TK - 1);
    end
    `CHK("frequency", freq_exp(GATE, 2), freq_value)
    repeat (4) begin
      r = rnd();
      lvl = r[0];
      out_level <= lvl;
      repeat (4) @(posedge clk);
      `CHK("direct out", lvl, field_out)
      `CHK("out status", lvl, output_status)
    end
    out_level <= 1'b0;
    ocfg.mode <= dio_pkg::OUT_PULSE;
    ocfg.high_width <= 16'h0002;
    ocfg.low_width <= 16'h0001;
    ocfg.total <= 32'h2;
    repeat (4) @(posedge clk);
    e0 = field.edges;
    `PULSE(pulse_start)
    ticks(8);
    `CHK("burst pulses", e0 + 2, field.edges)
    `CHK("high width", 2 * TK, field.high_len)
    ocfg.continuous <= 1'b1;
    e0 = field.edges;
    `PULSE(pulse_start)
    ticks(7);
    `CHK("train pulses", e0 + 3, field.edges)
    ocfg.delay <= 16'h0003;
    for (int i = 0; i < 2; i++) begin
      ocfg.mode <= i ? dio_pkg::OUT_DELAY_FALL : dio_pkg::OUT_DELAY_RISE;
      out_level <= i[0];
      repeat (4) @(posedge clk);
      out_level <= ~i[0];
      ticks(1);
      `CHK("delay early", i[0], field_out)
      ticks(4);
      `CHK("delay late", ~i[0], field_out)
    end
    ocfg.mode <= dio_pkg::OUT_DIRECT;
    ocfg.fail_safe <= 1'b1;
    out_level <= 1'b0;
    host_idle <= 16'h0002;
    peer_idle <= 16'h0002;
    peer_report_en <= 1'b1;
    `PULSE(host_packet)
    `PULSE(peer_packet)
    ticks(1);
    `CHK("host early", 1'b0, host_timeout)
    `CHK("safe early", 1'b0, field_out)
    ticks(4);
    `CHK("host late", 1'b1, host_timeout)
    `CHK("safe late", 1'b1, field_out)
    `CHK("peer late", 1'b1, peer_timeout)
    `CHK("fallback", 1'b1, fallback)
    wrap_up();
  end
endmodule : digital_io_channel_engine_bench
